// ### hdl/acs_pkg.sv
// package of the calibration-mode sequencer: register map, field layout,
// reset values, mode codes and the carrier struct.
// assumes a 32-bit axi4-lite register bus and a front end on the same clock.
package acs_pkg;

  // ===========================================================
  // register map (byte addresses)
  localparam int AXI_ADDR_W = 5;
  localparam logic [AXI_ADDR_W-1:0] OFF_MODE = 5'h00;
  localparam logic [AXI_ADDR_W-1:0] OFF_CHAN = 5'h04;
  localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 5'h08;
  localparam logic [AXI_ADDR_W-1:0] OFF_DATA = 5'h0c;
  localparam logic [AXI_ADDR_W-1:0] OFF_ZS_COEF = 5'h10;
  localparam logic [AXI_ADDR_W-1:0] OFF_FS_COEF = 5'h14;
  localparam logic [AXI_ADDR_W-1:0] OFF_INT_STAT = 5'h18;
  localparam logic [AXI_ADDR_W-1:0] OFF_INT_MASK = 5'h1c;

  // ===========================================================
  // field positions
  localparam int MODE_POS = 5;
  localparam int GAIN_POS = 2;
  localparam int BO_POS = 1;
  localparam int FSYNC_POS = 0;
  localparam int INT_DATA_POS = 0;
  localparam int INT_CAL_POS = 1;
  localparam int STAT_DATA_READY_N_POS = 0;
  localparam int STAT_BUSY_POS = 1;
  localparam int STAT_PHASE_POS = 2;
  localparam int STAT_SLOT_POS = 4;

  // ===========================================================
  // reset values and counts
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_CHAN = 3'h4;
  localparam logic [2:0] BG_RATIO = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ===========================================================
  // enumerations
  typedef enum logic [2:0] {
    MD_NORMAL = 3'b000,
    MD_SELF = 3'b001,
    MD_ZS_SYS = 3'b010,
    MD_FS_SYS = 3'b011,
    MD_SYS_OFFSET = 3'b100,
    MD_BACKGROUND = 3'b101,
    MD_ZS_SELF = 3'b110,
    MD_FS_SELF = 3'b111
  } acs_mode_type;

  typedef enum logic [1:0] {
    SRC_INPUT = 2'b00,
    SRC_SHORT = 2'b01,
    SRC_REF = 2'b10
  } acs_src_type;

  typedef enum logic [1:0] {
    PH_CONV = 2'b00,
    PH_ZS = 2'b01,
    PH_FS = 2'b10,
    PH_FINAL = 2'b11
  } acs_phase_type;

  // ===========================================================
  // carrier towards the analog front end
  typedef struct packed {
    acs_src_type src;
    logic [2:0] chan;
    logic [7:0] gain;
    logic burnout;
    logic fsync;
  } acs_fe_cmd_type;

endpackage

// ### hdl/acs_sequencer.sv
// calibration-mode sequencer: mode register, coefficient store, data word,
// data-ready pin and interrupt, reached over an axi4-lite slave.
// assumes a front end on aclk that returns one sample per sample_valid,
// measured with the settings last shown on fe_cmd.
//
// Overview of operation
// - mode 100 runs one system offset calibration on the selected channel
// - system offset zero-scale taken from the analog input at selected gain
// - system offset full-scale taken from reference divided by gain
// - data-ready high at system offset start, low once cal done and word ready
// - after any single-pass calibration the mode field returns to 000
// - mode 101 runs background zero-scale calibration on shorted inputs
// - background interleaves zero-scale slots, word rate falls by six
// - background writes fresh offset coefficients without host help
// - mode 110 runs one zero-scale self-calibration on shorted inputs
// - zero-scale self-cal: data-ready high at start, low when word ready
// - mode 111 runs one full-scale self-calibration against reference over gain
// - full-scale self-cal completion returns the mode field to 000
// - full-scale self-cal: data-ready high at start, low when word ready
// - mode register is all zeros after reset, selecting normal mode
// - data-ready status bit always equals the data-ready pin
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
module acs_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [acs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [acs_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front end
  input wire logic sample_valid,
  input wire logic [23:0] sample_data,
  output acs_pkg::acs_fe_cmd_type fe_cmd,
  // status pins
  output logic data_ready_n,
  output logic irq
);
  import acs_pkg::*;

  // ===========================================================
  // state
  typedef struct packed {
    logic [7:0] mode_reg;
    logic [2:0] chan_reg;
    acs_phase_type phase;
    logic [2:0] slot;
    logic [23:0] data_word;
    logic [2:0][23:0] zs_coef;
    logic [2:0][23:0] fs_coef;
    logic data_ready_n_n;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic irq;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    acs_fe_cmd_type fe;
  } acs_state_type;

  acs_state_type state_reg;
  acs_state_type state_next;

  // ===========================================================
  // decoders
  // channel to calibration register pair, shared pairs as in the channel map
  function automatic logic [1:0] pair_of(input logic [2:0] ch);
    case (ch)
      3'h0, 3'h4: pair_of = 2'h0;
      3'h1, 3'h5: pair_of = 2'h1;
      default: pair_of = 2'h2;
    endcase
  endfunction

  // gain code to gain factor
  function automatic logic [7:0] gain_of(input logic [2:0] code);
    gain_of = 8'h01 << code;
  endfunction

  // byte-lane merge for registers up to 24 bits wide
  function automatic logic [23:0] merge24(input logic [23:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge24 = old;
    for (int i = 0; i < 3; i++) begin
      if (strb[i]) begin
        merge24[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // ===========================================================
  // next-state logic
  always_comb begin
    logic [1:0] pair;
    logic [1:0] int_set;
    logic [1:0] int_clr;
    logic [23:0] status;
    acs_mode_type md;
    logic pub;
    pair = 2'h0;
    pub = 1'b0;
    int_set = 2'h0;
    int_clr = 2'h0;
    status = 24'h0;
    md = MD_NORMAL;
    state_next = state_reg;
    pair = pair_of(state_reg.chan_reg);
    md = acs_mode_type'(state_reg.mode_reg[MODE_POS +: 3]);

    // sample handling: conversion, calibration measurement or final word
    if (sample_valid) begin
      case (state_reg.phase)
        PH_CONV: begin
          if (md == MD_BACKGROUND) begin
            if (state_reg.slot == 3'h0) begin
              state_next.data_word = sample_data - state_reg.zs_coef[pair];
              state_next.data_ready_n_n = 1'b0;
              int_set[INT_DATA_POS] = 1'b1;
              pub = 1'b1;
            end else begin
              state_next.zs_coef[pair] = sample_data;
            end
            // one output word per six sample slots
            if (state_reg.slot == BG_RATIO - 3'h1) begin
              state_next.slot = 3'h0;
            end else begin
              state_next.slot = state_reg.slot + 3'h1;
            end
          end else begin
            state_next.data_word = sample_data - state_reg.zs_coef[pair];
            state_next.data_ready_n_n = 1'b0;
            int_set[INT_DATA_POS] = 1'b1;
            pub = 1'b1;
          end
        end
        PH_ZS: begin
          state_next.zs_coef[pair] = sample_data;
          if (md == MD_SYS_OFFSET) begin
            state_next.phase = PH_FS;
          end else begin
            state_next.phase = PH_FINAL;
          end
        end
        PH_FS: begin
          state_next.fs_coef[pair] = sample_data;
          state_next.phase = PH_FINAL;
        end
        PH_FINAL: begin
          // the word after calibration is the one that releases data-ready
          state_next.data_word = sample_data - state_next.zs_coef[pair];
          state_next.data_ready_n_n = 1'b0;
          pub = 1'b1;
          state_next.mode_reg[MODE_POS +: 3] = MD_NORMAL;
          state_next.phase = PH_CONV;
          state_next.slot = 3'h0;
          int_set = 2'h3;
        end
        default: begin
          state_next.phase = PH_CONV;
        end
      endcase
    end

    // write response handshake and channel capture
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata_q = s_axi_wdata;
      state_next.wstrb_q = s_axi_wstrb;
    end

    // register write once both halves are in and no response is pending
    if (state_next.aw_got && state_next.w_got && !state_next.bvalid) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      case (state_next.awaddr_q)
        OFF_MODE: begin
          if (state_next.wstrb_q[0]) begin
            // a new mode restarts the sequence, aborting any calibration
            state_next.mode_reg = state_next.wdata_q[7:0];
            state_next.slot = 3'h0;
            case (acs_mode_type'(state_next.wdata_q[MODE_POS +: 3]))
              MD_SYS_OFFSET: begin
                state_next.phase = PH_ZS;
                state_next.data_ready_n_n = 1'b1;
              end
              MD_ZS_SELF: begin
                state_next.phase = PH_ZS;
                state_next.data_ready_n_n = 1'b1;
              end
              MD_FS_SELF: begin
                state_next.phase = PH_FS;
                state_next.data_ready_n_n = 1'b1;
              end
              default: begin
                state_next.phase = PH_CONV;
              end
            endcase
          end
        end
        OFF_CHAN: begin
          if (state_next.wstrb_q[0]) begin
            state_next.chan_reg = state_next.wdata_q[2:0];
          end
        end
        OFF_ZS_COEF: begin
          state_next.zs_coef[pair] = merge24(state_next.zs_coef[pair], state_next.wdata_q,
                                             state_next.wstrb_q);
        end
        OFF_FS_COEF: begin
          state_next.fs_coef[pair] = merge24(state_next.fs_coef[pair], state_next.wdata_q,
                                             state_next.wstrb_q);
        end
        OFF_INT_STAT: begin
          if (state_next.wstrb_q[0]) begin
            int_clr = state_next.wdata_q[1:0];
          end
        end
        OFF_INT_MASK: begin
          if (state_next.wstrb_q[0]) begin
            state_next.int_mask = state_next.wdata_q[1:0];
          end
        end
        OFF_STATUS, OFF_DATA: begin
          state_next.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          state_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // read channel; data read marks the word as consumed
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = RESP_OKAY;
      state_next.rdata = 32'h0;
      status[STAT_DATA_READY_N_POS] = state_reg.data_ready_n_n;
      status[STAT_BUSY_POS] = (state_reg.phase != PH_CONV);
      status[STAT_PHASE_POS +: 2] = state_reg.phase;
      status[STAT_SLOT_POS +: 3] = state_reg.slot;
      case (s_axi_araddr)
        OFF_MODE: state_next.rdata[7:0] = state_reg.mode_reg;
        OFF_CHAN: state_next.rdata[2:0] = state_reg.chan_reg;
        OFF_STATUS: state_next.rdata[23:0] = status;
        OFF_DATA: begin
          state_next.rdata[23:0] = state_reg.data_word;
          // a word published in this same cycle keeps data-ready low
          // set wins: a word already standing is replaced, not lost
          if (!pub) begin
            state_next.data_ready_n_n = 1'b1;
          end
        end
        OFF_ZS_COEF: state_next.rdata[23:0] = state_reg.zs_coef[pair];
        OFF_FS_COEF: state_next.rdata[23:0] = state_reg.fs_coef[pair];
        OFF_INT_STAT: state_next.rdata[1:0] = state_reg.int_stat;
        OFF_INT_MASK: state_next.rdata[1:0] = state_reg.int_mask;
        default: state_next.rresp = RESP_SLVERR;
      endcase
    end

    // ready flags follow the pending state
    state_next.awready = !state_next.aw_got;
    state_next.wready = !state_next.w_got;
    state_next.arready = !state_next.rvalid;

    // sticky events: a set in the clearing cycle survives
    state_next.int_stat = (state_reg.int_stat & ~int_clr) | int_set;
    state_next.irq = |(state_next.int_stat & state_next.int_mask);

    // front-end command follows the next phase
    md = acs_mode_type'(state_next.mode_reg[MODE_POS +: 3]);
    state_next.fe.chan = state_next.chan_reg;
    state_next.fe.gain = gain_of(state_next.mode_reg[GAIN_POS +: 3]);
    state_next.fe.burnout = state_next.mode_reg[BO_POS];
    state_next.fe.fsync = state_next.mode_reg[FSYNC_POS];
    case (state_next.phase)
      PH_ZS: state_next.fe.src = (md == MD_SYS_OFFSET) ? SRC_INPUT : SRC_SHORT;
      PH_FS: state_next.fe.src = SRC_REF;
      PH_FINAL: state_next.fe.src = SRC_INPUT;
      default: begin
        if (md == MD_BACKGROUND && state_next.slot != 3'h0) begin
          state_next.fe.src = SRC_SHORT;
        end else begin
          state_next.fe.src = SRC_INPUT;
        end
      end
    endcase
  end

  // ===========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.mode_reg <= RST_MODE;
      state_reg.chan_reg <= RST_CHAN;
      state_reg.phase <= PH_CONV;
      state_reg.data_ready_n_n <= 1'b1;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.fe.chan <= RST_CHAN;
      state_reg.fe.gain <= 8'h01;
      state_reg.fe.src <= SRC_INPUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ===========================================================
  // outputs straight from the state register
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign fe_cmd = state_reg.fe;
  assign data_ready_n = state_reg.data_ready_n_n;
  assign irq = state_reg.irq;

endmodule

// ### tb/acs_seq_asserts.sv
// concurrent checks of the calibration-mode sequencer, seen at its ports only.
// assumes one clock domain with a synchronous active-low reset.
module acs_seq_asserts
  import acs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [acs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // front end and pin
  input wire logic sample_valid,
  input wire acs_pkg::acs_fe_cmd_type fe_cmd,
  input wire logic data_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ===========================================================
  // write address and data taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // such a write lands in the mode register
  sequence s_mode_take;
    s_wr_take ##0 (s_axi_awaddr == OFF_MODE && s_axi_wstrb[0]);
  endsequence
  // mode write with a given operating-mode code
  sequence s_mode_wr(c);
    s_mode_take ##0 (s_axi_wdata[7:5] == c);
  endsequence
  // ===========================================================
  property p_b_answer;
    s_wr_take |=> s_axi_bvalid;
  endproperty
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  // a calibration start holds the pin high while no sample has come
  property p_cal_busy;
    s_mode_take ##0 (s_axi_wdata[7] && s_axi_wdata[7:5] != 3'b101) |-> ##2 data_ready_n[*2];
  endproperty
  property p_sys_src;
    s_mode_wr(3'b100) |-> ##3 fe_cmd.src == SRC_INPUT;
  endproperty
  property p_zs_src;
    s_mode_wr(3'b110) |-> ##3 fe_cmd.src == SRC_SHORT;
  endproperty
  property p_fs_src;
    s_mode_wr(3'b111) |-> ##3 fe_cmd.src == SRC_REF;
  endproperty
  property p_gain;
    logic [2:0] g;
    (s_mode_take, g = s_axi_wdata[4:2]) |-> ##3 fe_cmd.gain == (8'h01 << g);
  endproperty
  // a new word only ever follows a sample
  property p_data_ready_n_fall;
    $fell(data_ready_n) |-> $past(sample_valid);
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  a_r_answer: assert property (p_r_answer) else $error("read data late");
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  a_cal_busy: assert property (p_cal_busy) else $error("ready low at cal start");
  a_sys_src: assert property (p_sys_src) else $error("offset cal not on input");
  a_zs_src: assert property (p_zs_src) else $error("zero self cal not shorted");
  a_fs_src: assert property (p_fs_src) else $error("full self cal not on ref");
  a_gain: assert property (p_gain) else $error("gain decode wrong");
  a_data_ready_n_fall: assert property (p_data_ready_n_fall) else $error("ready without sample");
endmodule
bind acs_sequencer acs_seq_asserts i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .sample_valid, .fe_cmd, .data_ready_n);

// ### tb/acs_fe_model.sv
// behavioural analog front end: one sample per request, measured per fe_cmd.
// assumes the bench raises req for one cycle per wanted sample.
module acs_fe_model
  import acs_pkg::*;
#(
  parameter logic [23:0] SHORT_OFS = 24'h000123,
  parameter logic [23:0] REF_FS = 24'h400000
)
(
  // clock
  input wire logic aclk,
  // bench side
  input wire logic req,
  input wire logic [23:0] ain,
  // sequencer side
  input wire acs_pkg::acs_fe_cmd_type fe_cmd,
  output logic sample_valid = 1'b0,
  output logic [23:0] sample_data = 24'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================================
  // outside a sample the data lines toggle, so a stale word is never seen as valid
  always @(posedge aclk) begin
    sample_valid <= req;
    if (req) begin
      case (fe_cmd.src)
        SRC_SHORT: sample_data <= SHORT_OFS + 24'(fe_cmd.chan);
        SRC_REF: sample_data <= REF_FS / 24'(fe_cmd.gain);
        default: sample_data <= ain;
      endcase
    end else begin
      sample_data <= ~sample_data;
    end
  end
endmodule

// ### tb/acs_sequencer_tb_top.sv
// self-checking bench of the calibration-mode sequencer with its front end.
// assumes the checker is bound to the sequencer from its own file.
module acs_sequencer_tb_top;
  import acs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] SHORT_OFS = 24'h000123;
  localparam logic [23:0] REF_FS = 24'h400000;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, req = 0, awready, wready, bvalid, arready, rvalid, sv, data_ready_n_n, irq;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp;
  logic [23:0] ain = 0, sd, a;
  logic [23:0] zs [3];
  logic [23:0] fs [3];
  acs_fe_cmd_type fe_cmd;
  logic [2:0] md, ch, g;
  int seed, i, k, p, miscompares, compares;

  acs_sequencer i_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sv), .sample_data(sd), .fe_cmd(fe_cmd), .data_ready_n(data_ready_n_n), .irq(irq));
  acs_fe_model #(.SHORT_OFS(SHORT_OFS), .REF_FS(REF_FS)) i_fe (.aclk, .req, .ain, .fe_cmd,
    .sample_valid(sv), .sample_data(sd));

  // ===========================================================
  // clock, 20 ns period
  always #10 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bus write: both channels offered together, each dropped once taken
  task automatic wr(input logic [4:0] ad, input logic [31:0] dt);
    logic at, wt;
    at = 0;
    wt = 0;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(at && wt)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        at = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wt = 1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", bresp, RESP_OKAY);
  endtask
  // bus read: rready held up until the data come
  task automatic rd(input logic [4:0] ad, output logic [31:0] dt);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
    dt = rdata;
    chk("rresp", rresp, RESP_OKAY);
  endtask
  // one front-end sample, then time for the word to land
  task automatic smp(input logic [23:0] v);
    @(posedge aclk);
    req <= 1'b1;
    ain <= v;
    @(posedge aclk);
    req <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  function automatic int pair_of(input logic [2:0] c);
    return (c == 0 || c == 4) ? 0 : (c == 1 || c == 5) ? 1 : 2;
  endfunction
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ===========================================================
  // watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    conclude();
  end

  // main sequence: calibrations, then background, with random channel and gain
  initial begin
    seed = 58546;
    zs = '{24'h0, 24'h0, 24'h0};
    fs = '{24'h0, 24'h0, 24'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_MODE, d);
    chk("mode at reset", d, 32'h0);
    rd(OFF_CHAN, d);
    chk("chan at reset", d, 32'h4);
    wr(OFF_INT_MASK, 32'h3);
    for (i = 0; i < 5; i++) begin
      md = (i == 0) ? 3'b100 : (i[0] ? 3'b110 : 3'b111);
      ch = 3'($random(seed));
      g = 3'($random(seed));
      p = pair_of(ch);
      wr(OFF_CHAN, {29'h0, ch});
      wr(OFF_MODE, {24'h0, md, g, 2'b00});
      for (k = 0; k < ((md == 3'b100) ? 3 : 2); k++) begin
        chk("ready during cal", data_ready_n_n, 1'b1);
        a = 24'($random(seed));
        if (k == 0 && md == 3'b100) zs[p] = a;
        if (k == 0 && md == 3'b110) zs[p] = SHORT_OFS + 24'(ch);
        if ((k == 1 && md == 3'b100) || (k == 0 && md == 3'b111)) fs[p] = REF_FS >> g;
        smp(a);
      end
      chk("ready after cal", data_ready_n_n, 1'b0);
      chk("irq after cal", irq, 1'b1);
      rd(OFF_MODE, d);
      chk("mode back to normal", d, {24'h0, 3'b000, g, 2'b00});
      rd(OFF_STATUS, d);
      chk("status ready bit", d[0], 1'b0);
      rd(OFF_ZS_COEF, d);
      chk("zero coef", d, {8'h0, zs[p]});
      rd(OFF_FS_COEF, d);
      chk("full coef", d, {8'h0, fs[p]});
      rd(OFF_DATA, d);
      chk("cal data word", d, {8'h0, a - zs[p]});
      rd(OFF_INT_STAT, d);
      chk("int status", d, 32'h3);
      wr(OFF_INT_STAT, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq cleared", irq, 1'b0);
    end
    // normal conversion once the mode field is back at 000
    a = 24'($random(seed));
    smp(a);
    chk("normal word ready", data_ready_n_n, 1'b0);
    rd(OFF_DATA, d);
    chk("normal data", d, {8'h0, a - zs[p]});
    // the last pass above was a full-scale self-calibration of this channel
    wr(OFF_INT_MASK, 32'h0);
    wr(OFF_MODE, {24'h0, 3'b101, g, 2'b00});
    for (k = 0; k < 12; k++) begin
      a = 24'($random(seed));
      if (k % 6 != 0) zs[p] = SHORT_OFS + 24'(ch);
      smp(a);
      chk("background word slot", data_ready_n_n, (k % 6 == 0) ? 1'b0 : 1'b1);
      chk("irq masked", irq, 1'b0);
      if (k % 6 == 0) begin
        rd(OFF_DATA, d);
        chk("background data", d, {8'h0, a - zs[p]});
      end
    end
    rd(OFF_MODE, d);
    chk("background mode kept", d, {24'h0, 3'b101, g, 2'b00});
    rd(OFF_ZS_COEF, d);
    chk("background zero coef", d, {8'h0, zs[p]});
    rd(OFF_FS_COEF, d);
    chk("background full coef", d, {8'h0, fs[p]});
    wr(OFF_INT_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", irq, 1'b1);
    wr(OFF_INT_STAT, 32'h3);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 1'b0);
    conclude();
  end
endmodule
